// file: spi_baud_defs.svh
// Overview of operation
// - In master mode the three-bit rate select field in status control bits 15 to 13 picks one of eight divisors while the range bit is clear.
// - In slave mode the rate select field has no effect at all.
// - Reset loads the rate select field with binary 011.
// - The master serial bit rate is the bus clock divided by the selected baud divisor.
// - With the range bit clear, codes 0 to 7 give divisors 2 to 256, doubled when the double bit is set.
// - With the range bit set, codes 0 to 4 give divisors 512 to 8192, doubled when the double bit is set.
// - With the range bit set, codes 5 to 7 give 16384 whatever the double bit says.
// - The shift order bit decides whether the MSB or the LSB is shifted out and sampled first.
// - Shift order zero means MSB first and one means LSB first.
// - Data registers always hold words right-aligned with the LSB at bit 0.
// - Words shorter than 16 bits are zero-padded in the upper bits.
// - Master and slave must use the same word length.
`ifndef SPI_BAUD_DEFS_SVH
`define SPI_BAUD_DEFS_SVH

// register indices; byte address is four times the index
`define SPI_IDX_STATUS       4'h0
`define SPI_IDX_DATA_SIZE    4'h1
`define SPI_IDX_RECEIVE      4'h2
`define SPI_IDX_TRANSMIT     4'h3

// status control fields
`define SPI_SC_RATE_HI       15
`define SPI_SC_RATE_LO       13
`define SPI_SC_SHIFT_ORDER   12
`define SPI_SC_MASTER        8
`define SPI_SC_ENABLE        1
`define SPI_SC_BUSY          0
`define SPI_RATE_RESET       3'h3
`define SPI_MASTER_RESET     1'h1

// data size fields
`define SPI_DS_LEN_HI        3
`define SPI_DS_LEN_LO        0
`define SPI_DS_RANGE         13
`define SPI_DS_DOUBLE        14
`define SPI_LEN_RESET        4'hF

// divisor exponents
`define SPI_EXP_LOW_BASE     4'h1
`define SPI_EXP_HIGH_BASE    4'h9
`define SPI_EXP_SAT          4'hE
`define SPI_RANGE_SAT_SEL    3'h5

`endif

// file: spi_baud_pkg.sv
package spi_baud_pkg;
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } spi_state_t;
endpackage : spi_baud_pkg

// file: spi_clk_divider.sv
`timescale 1ns/1ps
`include "spi_baud_defs.svh"
module spi_clk_divider #(
  parameter int CNT_W = 15
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       run,
  input  wire logic [2:0] rate_select_field,
  input  wire logic       rate_range_bit,
  input  wire logic       divisor_double_bit,
  // half-period ticks
  output logic            tick_rise,
  output logic            tick_fall
);
  logic [3:0]       exponent;
  logic [CNT_W-1:0] half_limit;
  logic [CNT_W-1:0] count;
  logic             phase;
  logic             tick;

  // baud divisor = 2**exponent
  always_comb begin
    if (rate_range_bit) begin
      if (rate_select_field >= `SPI_RANGE_SAT_SEL) begin
        exponent = `SPI_EXP_SAT;
      end else begin
        exponent = `SPI_EXP_HIGH_BASE + {1'b0, rate_select_field}
                   + {3'h0, divisor_double_bit};
      end
    end else begin
      exponent = `SPI_EXP_LOW_BASE + {1'b0, rate_select_field}
                 + {3'h0, divisor_double_bit};
    end
  end

  // half the divisor, minus one, in bus clocks
  assign half_limit = (CNT_W'(1) << (exponent - 4'h1)) - CNT_W'(1);
  assign tick       = run && (count == half_limit);
  assign tick_rise  = tick && !phase;
  assign tick_fall  = tick && phase;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      phase <= 1'b0;
    end else if (!run) begin
      count <= '0;
      phase <= 1'b0;
    end else if (tick) begin
      count <= '0;
      phase <= !phase;
    end else begin
      count <= count + CNT_W'(1);
    end
  end
endmodule : spi_clk_divider

// file: spi_baud_shift.sv
`timescale 1ns/1ps
`include "spi_baud_defs.svh"
module spi_baud_shift
  import spi_baud_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial clock
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  // master out slave in
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // master in slave out
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // slave select
  input  wire logic        ss_n
);
  logic [2:0]        rate_select_field;
  logic              shift_order_bit;
  logic              master;
  logic              enable;
  logic [3:0]        last_bit;
  logic              rate_range_bit;
  logic              divisor_double_bit;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] rx_data;
  spi_state_t        state;
  logic [3:0]        m_cnt;
  logic [DATA_W-1:0] m_acc;
  logic [3:0]        s_cnt;
  logic [DATA_W-1:0] s_acc;
  logic [DATA_W-1:0] next_s_acc;
  logic              sclk_prev;
  logic              tick_rise;
  logic              tick_fall;
  logic              setup;
  logic              wr_en;
  logic [3:0]        index;
  logic              mapped;
  logic              start;
  logic              m_done;
  logic              s_active;
  logic              s_rise;
  logic              s_fall;
  logic              s_done;
  logic [31:0]       read_word;

  // bit position in the word for the n-th bit on the wire
  function automatic logic [3:0] bit_pos(input logic lsb_first, input logic [3:0] n,
                                         input logic [3:0] last);
    bit_pos = lsb_first ? n : last - n;
  endfunction : bit_pos

  assign setup  = psel && !penable;
  assign wr_en  = psel && penable && pready && pwrite && !pslverr;
  assign index  = paddr[5:2];
  assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0)
                  && (index <= `SPI_IDX_TRANSMIT);
  assign start  = wr_en && (index == `SPI_IDX_TRANSMIT) && enable && master
                  && (state == ST_IDLE);
  assign m_done = (state == ST_SHIFT) && tick_fall && (m_cnt == last_bit);

  // slave ignores the rate fields entirely
  assign s_active = enable && !master && !ss_n;
  assign s_rise   = s_active && sclk_in && !sclk_prev;
  assign s_fall   = s_active && !sclk_in && sclk_prev;
  assign s_done   = s_rise && (s_cnt == last_bit);

  always_comb begin
    next_s_acc = s_acc;
    next_s_acc[bit_pos(shift_order_bit, s_cnt, last_bit)] = mosi_in;
  end

  always_comb begin
    read_word = 32'h0000_0000;
    case (index)
      `SPI_IDX_STATUS: begin
        read_word[`SPI_SC_RATE_HI:`SPI_SC_RATE_LO] = rate_select_field;
        read_word[`SPI_SC_SHIFT_ORDER]             = shift_order_bit;
        read_word[`SPI_SC_MASTER]                  = master;
        read_word[`SPI_SC_ENABLE]                  = enable;
        read_word[`SPI_SC_BUSY]                    = (state == ST_SHIFT);
      end
      `SPI_IDX_DATA_SIZE: begin
        read_word[`SPI_DS_LEN_HI:`SPI_DS_LEN_LO] = last_bit;
        read_word[`SPI_DS_RANGE]                 = rate_range_bit;
        read_word[`SPI_DS_DOUBLE]                = divisor_double_bit;
      end
      `SPI_IDX_RECEIVE: begin
        read_word[DATA_W-1:0] = rx_data;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  // apb answer: one wait-free access phase after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && mapped && !pwrite) ? read_word : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_select_field  <= `SPI_RATE_RESET;
      shift_order_bit    <= 1'b0;
      master             <= `SPI_MASTER_RESET;
      enable             <= 1'b0;
      last_bit           <= `SPI_LEN_RESET;
      rate_range_bit     <= 1'b0;
      divisor_double_bit <= 1'b0;
      tx_data            <= '0;
    end else if (wr_en) begin
      case (index)
        `SPI_IDX_STATUS: begin
          rate_select_field <= pwdata[`SPI_SC_RATE_HI:`SPI_SC_RATE_LO];
          shift_order_bit   <= pwdata[`SPI_SC_SHIFT_ORDER];
          master            <= pwdata[`SPI_SC_MASTER];
          enable            <= pwdata[`SPI_SC_ENABLE];
        end
        `SPI_IDX_DATA_SIZE: begin
          last_bit           <= pwdata[`SPI_DS_LEN_HI:`SPI_DS_LEN_LO];
          rate_range_bit     <= pwdata[`SPI_DS_RANGE];
          divisor_double_bit <= pwdata[`SPI_DS_DOUBLE];
        end
        `SPI_IDX_TRANSMIT: begin
          tx_data <= pwdata[DATA_W-1:0];
        end
        default: begin
          tx_data <= tx_data;
        end
      endcase
    end
  end

  spi_clk_divider u_div (
    .pclk               (pclk),
    .presetn            (presetn),
    .run                (state == ST_SHIFT),
    .rate_select_field  (rate_select_field),
    .rate_range_bit     (rate_range_bit),
    .divisor_double_bit (divisor_double_bit),
    .tick_rise          (tick_rise),
    .tick_fall          (tick_fall)
  );

  // master transfer, sample on rising, shift on falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      m_cnt    <= 4'h0;
      m_acc    <= '0;
      mosi_out <= 1'b0;
      sclk_out <= 1'b0;
    end else if (!enable || !master) begin
      state    <= ST_IDLE;
      sclk_out <= 1'b0;
    end else if (start) begin
      state    <= ST_SHIFT;
      m_cnt    <= 4'h0;
      m_acc    <= '0;
      mosi_out <= pwdata[bit_pos(shift_order_bit, 4'h0, last_bit)];
    end else if (state == ST_SHIFT) begin
      if (tick_rise) begin
        sclk_out <= 1'b1;
        m_acc[bit_pos(shift_order_bit, m_cnt, last_bit)] <= miso_in;
      end
      if (tick_fall) begin
        sclk_out <= 1'b0;
        if (m_done) begin
          state <= ST_IDLE;
        end else begin
          m_cnt    <= m_cnt + 4'h1;
          mosi_out <= tx_data[bit_pos(shift_order_bit, m_cnt + 4'h1, last_bit)];
        end
      end
    end
  end

  // slave transfer on the incoming clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev <= 1'b0;
      s_cnt     <= 4'h0;
      s_acc     <= '0;
      miso_out  <= 1'b0;
    end else begin
      sclk_prev <= sclk_in;
      if (!s_active) begin
        s_cnt <= 4'h0;
        s_acc <= '0;
      end else if (s_rise) begin
        s_acc <= s_done ? '0 : next_s_acc;
      end else if (s_fall) begin
        s_cnt <= (s_cnt == last_bit) ? 4'h0 : s_cnt + 4'h1;
      end
      miso_out <= tx_data[bit_pos(shift_order_bit, s_cnt, last_bit)];
    end
  end

  // received word, right-aligned and zero-padded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= '0;
    end else if (m_done) begin
      rx_data <= m_acc;
    end else if (s_done) begin
      rx_data <= next_s_acc;
    end
  end

  // pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sclk_oe <= enable && master;
      mosi_oe <= enable && master;
      miso_oe <= s_active;
    end
  end
endmodule : spi_baud_shift

// file: spi_baud_props.sv
`timescale 1ns/1ps
module spi_baud_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial pins
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        mosi_out,
  input wire logic        mosi_oe,
  input wire logic        miso_oe,
  input wire logic        ss_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [14:0] hi_cnt;
  // counts how long the serial clock has stayed high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 15'h0000;
    else hi_cnt <= sclk_out ? hi_cnt + 15'h0001 : 15'h0000;
  end
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer not clean");
  pad_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  clk_idle_a: assert property (!sclk_oe |-> !sclk_out)
    else $error("serial clock driven while not master");
  slave_quiet_a: assert property (miso_oe |-> !sclk_oe && !mosi_oe && !$past(ss_n))
    else $error("slave output without select");
  bit_setup_a: assert property ($rose(sclk_out) |-> $stable(mosi_out))
    else $error("data moved on sampling edge");
  half_bound_a: assert property (hi_cnt <= 15'h2000)
    else $error("serial clock half period too long");
  oe_pair_a: assert property (sclk_oe == mosi_oe)
    else $error("master enables differ");
  cover property ($rose(sclk_out));
  cover property (miso_oe);
  cover property (pslverr);
endmodule : spi_baud_chk

bind spi_baud_shift spi_baud_chk i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .sclk_out, .sclk_oe, .mosi_out, .mosi_oe, .miso_oe, .ss_n);

// file: spi_peer.sv
`timescale 1ns/1ps
module spi_peer (
  input  wire logic        pclk,
  input  wire logic        sclk,
  input  wire logic        mosi,
  input  wire logic        ss_n,
  input  wire logic        lsb_first,
  input  wire logic [3:0]  last,
  input  wire logic [15:0] tx_word,
  output logic             miso,
  output logic [15:0]      rx_word
);
  logic [3:0] cnt = 4'h0;
  logic       idle_bit = 1'b0;
  function automatic int pos(int n);
    return lsb_first ? n : int'(last) - n;
  endfunction : pos
  // the serial clock idles low, so a low clock here marks the select edge
  always @(posedge sclk or negedge ss_n) begin
    if (!sclk) rx_word <= 16'h0000;
    else if (!ss_n) rx_word[pos(cnt)] <= mosi;
  end
  always @(negedge sclk or posedge ss_n) cnt <= ss_n ? 4'h0 : cnt + 4'h1;
  // released line wanders so a stale value is never mistaken for data
  always @(posedge pclk) idle_bit <= ~idle_bit;
  assign miso = ss_n ? idle_bit : tx_word[pos(cnt)];
endmodule : spi_peer

// file: spi_baud_and_shift_order_tb_top.sv
`timescale 1ns/1ps
module spi_baud_and_shift_order_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, tb_sclk, tb_mosi, ss_n, lsb;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  wire logic   sclk_in, mosi_in, miso_in, peer_miso;
  logic [15:0] peer_rx, peer_tx, w, lfsr;
  logic [32:0] notes[$];
  int          mismatches, n_checks, cyc, t;
  assign sclk_in = sclk_oe ? sclk_out : tb_sclk;
  assign mosi_in = mosi_oe ? mosi_out : tb_mosi;
  assign miso_in = miso_oe ? miso_out : peer_miso;
  spi_baud_shift i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sclk_in, .sclk_out, .sclk_oe, .mosi_in, .mosi_out, .mosi_oe,
    .miso_in, .miso_out, .miso_oe, .ss_n);
  spi_peer i_peer (.pclk, .sclk(sclk_in), .mosi(mosi_in), .ss_n, .lsb_first(lsb),
    .last(4'h4), .tx_word(peer_tx), .miso(peer_miso), .rx_word(peer_rx));
  function automatic logic [31:0] st(logic [2:0] s, logic o, logic m, logic e);
    return {16'h0000, s, o, 3'h0, m, 6'h00, e, 1'b0};
  endfunction : st
  function automatic int bd(logic r, logic d, logic [2:0] s);
    return (r && s >= 3'h5) ? 16384 : ((r ? 512 : 2) << s) << d;
  endfunction : bd
  task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    notes.push_back(e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic rate(logic r, logic d, logic [2:0] s);
    apb(1, 8'h04, {17'h0, d, r, 9'h000, 4'h4}, 33'h0);
    apb(1, 8'h00, st(s, 0, 1, 1), 33'h0);
    apb(1, 8'h0C, 32'h0000_0000, 33'h0);
    while (sclk_out !== 1'b1) @(posedge pclk);
    t = 0;
    while (sclk_out === 1'b1) begin
      @(posedge pclk);
      t++;
    end
    chk("half period", bd(r, d, s) / 2, t);
    apb(1, 8'h00, st(s, 0, 1, 0), 33'h0);
  endtask : rate
  // result monitor: every access answer against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1 && notes.size() > 0) chk("apb answer", notes.pop_front(), {pslverr, prdata});
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    tb_sclk = 1'b0;
    tb_mosi = 1'b0;
    ss_n    = 1'b1;
    lsb     = 1'b0;
    lfsr    = 16'h0024;
    peer_tx = 16'h0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h00, 32'h0, {1'b0, 32'h0000_6100});
    apb(0, 8'h04, 32'h0, {1'b0, 32'h0000_000F});
    apb(0, 8'h0C, 32'h0, 33'h0);
    apb(0, 8'h10, 32'h0, {1'b1, 32'h0});
    for (int i = 0; i < 16; i++) rate(0, i[3], i[2:0]);
    rate(1, 1, 3'h0);
    rate(1, 0, 3'h4);
    rate(1, 1, 3'h5);
    rate(1, 0, 3'h7);
    for (int o = 0; o < 2; o++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      w = lfsr;
      peer_tx = ~lfsr;
      lsb = o[0];
      ss_n <= 1'b0;
      apb(1, 8'h04, 32'h0000_0004, 33'h0);
      // divisor 4 keeps the link at 25 MHz
      apb(1, 8'h00, st(1, o[0], 1, 1), 33'h0);
      apb(1, 8'h0C, {16'h0, w}, 33'h0);
      repeat (30) @(posedge pclk);
      ss_n <= 1'b1;
      apb(0, 8'h00, 32'h0, {1'b0, st(1, o[0], 1, 1)});
      apb(0, 8'h08, 32'h0, {28'h0, peer_tx[4:0]});
      chk("peer word", {28'h0, w[4:0]}, {28'h0, peer_rx[4:0]});
    end
    w = lfsr;
    apb(1, 8'h00, st(7, 0, 0, 1), 33'h0);
    ss_n <= 1'b0;
    // transmit word still holds w from the last master frame
    for (int i = 4; i >= 0; i--) begin
      tb_mosi <= w[i];
      repeat (3) @(posedge pclk);
      chk("slave out", {32'h0, w[i]}, {32'h0, miso_out});
      chk("slave enable", 33'h1, {32'h0, miso_oe});
      tb_sclk <= 1'b1;
      repeat (3) @(posedge pclk);
      tb_sclk <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    ss_n <= 1'b1;
    apb(0, 8'h08, 32'h0, {28'h0, w[4:0]});
    final_report();
  end
endmodule : spi_baud_and_shift_order_tb_top
